// ### verilog/sbcm_top.sv
// Sync bit clock measurement: selection copies, window timer, result
//
// The implementer's own choices: the register addresses and the strobed register port.
`include "sbcm_params.svh"
module sbcm_top (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Register bus
  input  wire sbcm_pkg::sbcm_bus_req_t bus_req,
  output logic [15:0]                rdata,
  // Decoder side
  input  wire logic [2:0]            sync_bit,
  input  wire logic [2:0]            decoder_lock,
  // Reference clock pin, about 32 kHz
  input  wire logic                  ref_clk_in,
  // Status
  output logic                       measure_busy
);
  logic               rst_n_s;
  logic               ref_s;
  logic [1:0]         sel_sup;
  logic [1:0]         sel_proc;
  logic               second_core_enable;
  logic [1:0]         next_sel_sup;
  logic [1:0]         next_sel_proc;
  logic               next_second_core_enable;
  logic [1:0]         cur_sel;
  logic               wr_status;
  logic               wr_active;
  logic [1:0]         wsel;
  logic               start;
  logic               ref_edge;
  logic               sync_hit;
  sbcm_pkg::sbcm_meas_t meas;
  sbcm_pkg::sbcm_meas_t next_meas;
  logic [15:0]        next_rdata;
  logic               next_busy;

  // Whole status reset word, so the selection field can be sliced from it
  localparam logic [7:0] status_rst = `SBCM_STATUS_RESET;

  // Reset release through two flip-flops
  sbcm_sync #(.W(1)) u_rst_sync (
    .clk   (clk),
    .rst_n (rstn),
    .d     (1'b1),
    .q     (rst_n_s)
  );

  // Reference pin comes from another domain
  sbcm_sync #(.W(1)) u_ref_sync (
    .clk   (clk),
    .rst_n (rst_n_s),
    .d     (ref_clk_in),
    .q     (ref_s)
  );

  // Bus decode of selection writes
  assign wr_status = bus_req.wr && (bus_req.addr == `SBCM_OFS_STATUS);
  assign wsel      = bus_req.wdata[`SBCM_SEL_MSB:`SBCM_SEL_LSB];
  assign wr_active = wr_status && (bus_req.core == second_core_enable);
  assign start     = wr_active && (wsel != `SBCM_SEL_OFF);
  assign cur_sel   = second_core_enable ? sel_proc : sel_sup;
  assign ref_edge  = ref_s && !meas.ref_d;
  assign sync_hit  = |(sync_bit & (3'h1 << meas.dec_idx));

  // Both copies always writable; only the owner's copy matters
  always_comb
  begin
    next_sel_sup            = sel_sup;
    next_sel_proc           = sel_proc;
    next_second_core_enable = second_core_enable;
    if (wr_status && !bus_req.core)
      next_sel_sup = wsel;
    if (wr_status && bus_req.core)
      next_sel_proc = wsel;
    if (bus_req.wr && (bus_req.addr == `SBCM_OFS_CONTROL))
      next_second_core_enable = bus_req.wdata[0];
  end

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      sel_sup            <= status_rst[`SBCM_SEL_MSB:`SBCM_SEL_LSB];
      sel_proc           <= status_rst[`SBCM_SEL_MSB:`SBCM_SEL_LSB];
      second_core_enable <= 1'b0;
    end
    else
    begin
      sel_sup            <= next_sel_sup;
      sel_proc           <= next_sel_proc;
      second_core_enable <= next_second_core_enable;
    end
  end

  // Measurement engine; a fresh start wins over any abort
  always_comb
  begin
    next_meas       = meas;
    next_meas.ref_d = ref_s;
    if (start)
    begin
      next_meas.state    = sbcm_pkg::SBCM_MEASURE;
      next_meas.dec_idx  = wsel;
      next_meas.ref_cnt  = 9'h000;
      next_meas.sync_cnt = 16'h0000;
      next_meas.result   = `SBCM_RESULT_RESET;
    end
    else
    begin
      case (meas.state)
        sbcm_pkg::SBCM_IDLE:
        begin
          next_meas.state = sbcm_pkg::SBCM_IDLE;
        end
        sbcm_pkg::SBCM_MEASURE:
        begin
          if (cur_sel == `SBCM_SEL_OFF)
            next_meas.state = sbcm_pkg::SBCM_IDLE;
          else
          begin
            // Saturate rather than wrap so a runaway input reads large
            if (sync_hit && (meas.sync_cnt != `SBCM_COUNT_MAX))
              next_meas.sync_cnt = meas.sync_cnt + 16'h0001;
            if (ref_edge)
            begin
              next_meas.ref_cnt = meas.ref_cnt + 9'h001;
              if (meas.ref_cnt == `SBCM_WINDOW_LAST)
              begin
                next_meas.state  = sbcm_pkg::SBCM_IDLE;
                next_meas.result = next_meas.sync_cnt;
              end
            end
          end
        end
        default:
        begin
          next_meas.state = sbcm_pkg::SBCM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      meas.state    <= sbcm_pkg::SBCM_IDLE;
      meas.dec_idx  <= `SBCM_SEL_OFF;
      meas.ref_cnt  <= 9'h000;
      meas.sync_cnt <= 16'h0000;
      meas.result   <= `SBCM_RESULT_RESET;
      meas.ref_d    <= 1'b0;
    end
    else
      meas <= next_meas;
  end

  // Read data one cycle after the strobe, zero otherwise
  always_comb
  begin
    next_rdata = 16'h0000;
    next_busy  = (next_meas.state == sbcm_pkg::SBCM_MEASURE);
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        `SBCM_OFS_STATUS:
          next_rdata = {8'h00, 2'h0, (bus_req.core ? sel_proc : sel_sup),
                        1'b0, decoder_lock};
        `SBCM_OFS_RESULT:
          next_rdata = meas.result;
        `SBCM_OFS_CONTROL:
          next_rdata = {15'h0000, second_core_enable};
        default:
          next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rdata        <= 16'h0000;
      measure_busy <= 1'b0;
    end
    else
    begin
      rdata        <= next_rdata;
      measure_busy <= next_busy;
    end
  end

  // Checks
  logic rd_status_q;

  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      rd_status_q <= 1'b0;
    else
      rd_status_q <= bus_req.rd && (bus_req.addr == `SBCM_OFS_STATUS);
  end

  sequence window_close_s;
    measure_busy && ref_edge && (meas.ref_cnt == 9'h1FF) && !start && (cur_sel != 2'h3);
  endsequence

  disabled_stays_idle_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    (cur_sel == 2'h3) && !start |=> !measure_busy)
    else $error("measurement runs while disabled");
  start_sets_busy_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    start |=> measure_busy && (meas.ref_cnt == 9'h000))
    else $error("selection write did not start interval");
  busy_result_zero_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    start |=> (meas.result == 16'h0000) [*2])
    else $error("result not zero while busy");
  decoder_pick_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    start |=> (meas.dec_idx == $past(wsel)))
    else $error("wrong decoder chosen");
  owner_write_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    wr_status && (bus_req.core == second_core_enable) && (wsel != 2'h3) |=> measure_busy)
    else $error("owner write did not start");
  inactive_copy_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    wr_status && (bus_req.core != second_core_enable) && !measure_busy
    && !(next_meas.state == sbcm_pkg::SBCM_MEASURE) |=> !measure_busy)
    else $error("inactive copy steered measurement");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    rd_status_q |-> (rdata[7:6] == 2'h0) && (rdata[3] == 1'b0))
    else $error("reserved status bits not zero");
  window_end_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    window_close_s |=> !measure_busy && (meas.result == meas.sync_cnt))
    else $error("window end did not load result");
  reset_value_a: assert property (@(posedge clk)
    $rose(rst_n_s) |-> (sel_sup == 2'h3) && (sel_proc == 2'h3) && !measure_busy)
    else $error("selection reset value wrong");
  no_restart_a: assert property (@(posedge clk) disable iff (!rst_n_s)
    !measure_busy && !start |=> !measure_busy)
    else $error("measurement began without request");
endmodule

// ### verilog/sbcm_params.svh
// Constants of the sync bit clock measurement block
// Notes on behaviour
// - Selection all ones keeps measurement disabled.
// - Non-disable selection write to the active copy starts one interval.
// - Result reads zero while measurement busy.
// - Values 00b/01b/10b pick decoder 0/1/2.
// - Enable bit picks supervisor or processing copy.
// - Inactive copy writable but steers nothing.
// - Status bits 7:6 read as zero.
// - Count sync bits over 512 reference periods.
// - Status resets to 30h, measurement disabled.
`ifndef SBCM_PARAMS_SVH
`define SBCM_PARAMS_SVH
`define SBCM_ADDR_W        4
`define SBCM_DATA_W        16
`define SBCM_OFS_STATUS    4'h0
`define SBCM_OFS_RESULT    4'h1
`define SBCM_OFS_CONTROL   4'h2
`define SBCM_SEL_LSB       4
`define SBCM_SEL_MSB       5
`define SBCM_SEL_OFF       2'h3
`define SBCM_STATUS_RESET  8'h30
`define SBCM_RESULT_RESET  16'h0000
`define SBCM_WINDOW_LAST   9'h1FF
`define SBCM_COUNT_MAX     16'hFFFF
`endif

// ### verilog/sbcm_pkg.sv
// Types of the sync bit clock measurement block
package sbcm_pkg;
  typedef enum logic [0:0] {
    SBCM_IDLE    = 1'b0,
    SBCM_MEASURE = 1'b1
  } sbcm_state_t;

  // One register bus request from either core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        core;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } sbcm_bus_req_t;

  // Measurement engine state
  typedef struct packed {
    sbcm_state_t state;
    logic [1:0]  dec_idx;
    logic [8:0]  ref_cnt;
    logic [15:0] sync_cnt;
    logic [15:0] result;
    logic        ref_d;
  } sbcm_meas_t;
endpackage

// ### verilog/sbcm_sync.sv
// Two flip-flop synchroniser, one per bit
module sbcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### verification/sbcm_far_model.sv
// Far side model: decoder sync pulses, lock levels, reference clock
module sbcm_far_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Decoder side
  output logic [2:0] sync_bit,
  output logic [2:0] decoder_lock,
  output logic       ref_clk_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tick;
  // Free running divider; real reference never stops either
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick <= 8'h00;
    else
      tick <= tick + 8'h01;
  end
  // Reference stand-in, one period per 4 clk
  assign ref_clk_in = tick[1];
  // Decoder i pulses every 4 << i clk, so counts tell decoders apart
  assign sync_bit[0] = (tick[1:0] == 2'h0);
  assign sync_bit[1] = (tick[2:0] == 3'h0);
  assign sync_bit[2] = (tick[3:0] == 4'h0);
  assign decoder_lock = 3'h5;
endmodule

// ### verification/sync_bit_clock_measure_bench.sv
// Self-checking bench for the sync bit clock measurement block
module sync_bit_clock_measure_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  sbcm_pkg::sbcm_bus_req_t bus_req = '0;
  logic [15:0]             rdata;
  logic [2:0]              sync_bit;
  logic [2:0]              decoder_lock;
  logic                    ref_clk_in;
  logic                    measure_busy;
  logic [15:0]             rv;
  int                      err_total = 0;
  int                      num_checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  sbcm_top dut_u (.clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
    .sync_bit(sync_bit), .decoder_lock(decoder_lock), .ref_clk_in(ref_clk_in),
    .measure_busy(measure_busy));
  sbcm_far_model far_u (.clk(clk), .rstn(rstn), .sync_bit(sync_bit),
    .decoder_lock(decoder_lock), .ref_clk_in(ref_clk_in));
  // Bus cycles, changed just after the edge
  task automatic bus_wr(input logic c, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, core: c, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
  endtask
  task automatic bus_rd(input logic c, input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, core: c, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = rdata;
  endtask
  // Comparisons
  task automatic check_eq(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_rng(input string n, input int lo, input int hi, input logic [15:0] g);
    num_checks++;
    if (^g === 1'bx || g < lo || g > hi)
    begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // One full interval; bounded wait, about 2048 clk per window
  task automatic measure(input logic c, input logic [1:0] s, input int lo, input int hi);
    bus_wr(c, 4'h0, {10'h000, s, 4'h0});
    check_eq("busy start", 16'h0001, {15'h0000, measure_busy});
    bus_rd(c, 4'h1, rv);
    check_eq("result busy", 16'h0000, rv);
    // Only the requesting core polls the result word; the other stays silent
    for (int i = 0; i < 1500 && rv === 16'h0000; i++)
      bus_rd(c, 4'h1, rv);
    check_rng("result", lo, hi, rv);
    check_eq("idle at end", 16'h0000, {15'h0000, measure_busy});
    repeat (20) @(negedge clk);
    check_eq("no rerun", 16'h0000, {15'h0000, measure_busy});
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rd(1'b0, 4'h0, rv);
    check_eq("status reset", 16'h0035, rv);
    bus_rd(1'b0, 4'h1, rv);
    check_eq("result reset", 16'h0000, rv);
    bus_rd(1'b0, 4'h3, rv);
    check_eq("unmapped", 16'h0000, rv);
    bus_wr(1'b0, 4'h0, 16'h00F0);
    check_eq("disabled", 16'h0000, {15'h0000, measure_busy});
    bus_rd(1'b0, 4'h0, rv);
    check_eq("reserved", 16'h0035, rv);
    for (int s = 0; s < 3; s++)
      measure(1'b0, s[1:0], (512 >> s) - 2, (512 >> s) + 2);
    bus_wr(1'b1, 4'h0, 16'h0000);
    check_eq("non owner", 16'h0000, {15'h0000, measure_busy});
    bus_rd(1'b1, 4'h0, rv);
    check_eq("second copy", 16'h0005, rv);
    bus_wr(1'b0, 4'h2, 16'h0001);
    check_eq("handover", 16'h0000, {15'h0000, measure_busy});
    bus_rd(1'b0, 4'h2, rv);
    check_eq("owner bit", 16'h0001, rv);
    measure(1'b1, 2'h1, 254, 258);
    bus_wr(1'b1, 4'h0, 16'h0000);
    bus_wr(1'b1, 4'h0, 16'h0030);
    @(negedge clk); // Owner copy reaches the engine one cycle later
    check_eq("abort", 16'h0000, {15'h0000, measure_busy});
    bus_rd(1'b1, 4'h1, rv);
    check_eq("abort result", 16'h0000, rv);
    stop_test;
  end
  // Watchdog, well past the four full intervals above
  initial
  begin
    repeat (40000) @(posedge clk);
    err_total++;
    stop_test;
  end
endmodule
